// ==== core/tmsi_defines.svh ====
// Purpose: constants for the temperature monitor serial interface
// Assumes: 100 MHz system clock
// Notes:   included by both ends, not by the package
`ifndef TMSI_DEFINES_SVH
`define TMSI_DEFINES_SVH
`define TMSI_ADDR_PRIMARY    7'h4c
`define TMSI_ADDR_ALTERNATE  7'h4d
`define TMSI_REG_LOCAL_TEMP  8'h00
`define TMSI_REG_REM_HI      8'h01
`define TMSI_REG_STATUS      8'h02
`define TMSI_RD_CONFIG       8'h03
`define TMSI_RD_LAST_SPLIT   8'h08
`define TMSI_WR_CONFIG       8'h09
`define TMSI_WR_LAST_SPLIT   8'h0e
`define TMSI_WR_ONESHOT      8'h0f
`define TMSI_REG_REM_LO      8'h10
`define TMSI_REG_OFS_HI      8'h11
`define TMSI_REG_OFS_LO      8'h12
`define TMSI_REG_RHL_LO      8'h13
`define TMSI_REG_RLL_LO      8'h14
`define TMSI_REG_REM_CRIT    8'h19
`define TMSI_REG_LOC_CRIT    8'h20
`define TMSI_REG_HYST        8'h21
`define TMSI_REG_FILTER      8'h22
`define TMSI_REG_MAKER       8'hfe
`define TMSI_REG_REVISION    8'hff
`define TMSI_RST_CONVRATE    8'h08
`define TMSI_RST_LIMIT_HI    8'h55
`define TMSI_RST_HYST        8'h0a
`define TMSI_RST_FILTER      8'h01
`define TMSI_ZERO_BYTE       8'h00
`define TMSI_TIMEOUT_BIT     7
`define TMSI_TIMEOUT_MS      25
`define TMSI_CLK_MHZ         100
`define TMSI_TIMEOUT_CYCLES  (`TMSI_TIMEOUT_MS * 1000 * `TMSI_CLK_MHZ)
`define TMSI_HOST_HALF       8
`endif

// ==== core/tmsi_pkg.sv ====
// Purpose: shared types for the serial interface ends
// Assumes: tmsi_defines.svh holds all numbers
// Notes:   none
`default_nettype none
package tmsi_pkg;
   typedef logic [7:0] tmsi_byte_t;
   typedef enum logic [2:0] {
      TMSI_IDLE  = 3'b000,
      TMSI_ADDR  = 3'b001,
      TMSI_AACK  = 3'b011,
      TMSI_WBYTE = 3'b010,
      TMSI_WACK  = 3'b110,
      TMSI_RBYTE = 3'b111,
      TMSI_RACK  = 3'b101,
      TMSI_SKIP  = 3'b100
   } tmsi_dev_state_t;
   typedef enum logic [3:0] {
      TMSH_IDLE  = 4'b0000,
      TMSH_START = 4'b0001,
      TMSH_BITLO = 4'b0011,
      TMSH_BITHI = 4'b0010,
      TMSH_NEXT  = 4'b0110,
      TMSH_STOPA = 4'b0111,
      TMSH_STOPB = 4'b0101,
      TMSH_STOPC = 4'b0100,
      TMSH_DONE  = 4'b1100
   } tmsi_host_state_t;
endpackage : tmsi_pkg
`default_nettype wire

// ==== core/tmsi_bus_if.sv ====
// Purpose: two-wire bus between host and monitor
// Assumes: open drain, enable low means driving low
// Notes:   wire level is the and of all releases
`default_nettype none
interface tmsi_bus_if;
   logic hostClkOut;
   logic hostClkOe_n;
   logic hostDataOut;
   logic hostDataOe_n;
   logic devDataOut;
   logic devDataOe_n;
   logic busClk;
   logic busData;
   assign busClk  = hostClkOe_n ? 1'b1 : hostClkOut;
   assign busData = (hostDataOe_n ? 1'b1 : hostDataOut) & (devDataOe_n ? 1'b1 : devDataOut);
   modport host (output hostClkOut, output hostClkOe_n, output hostDataOut, output hostDataOe_n,
                 input busClk, input busData);
   modport device (output devDataOut, output devDataOe_n, input busClk, input busData);
endinterface : tmsi_bus_if
`default_nettype wire

// ==== core/tmsi_device.sv ====
// Purpose: serial slave end and register map of the temperature monitor
// Assumes: bus pins asynchronous to clk_sys, sampled by two flops
// Notes:   measurement values arrive as inputs from the conversion logic
`default_nettype none
`include "tmsi_defines.svh"
module tmsi_device #(
   parameter int unsigned TIMEOUT_CYCLES = `TMSI_TIMEOUT_CYCLES,
   parameter logic [7:0]  MAKER_CODE     = 8'h5a, // arbitrary value
   parameter logic [7:0]  REVISION_CODE  = 8'h01  // arbitrary value
) (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               srst,
   // strap
   input  wire logic               altAddress,
   // measurement inputs
   input  wire tmsi_pkg::tmsi_byte_t localTemp,
   input  wire tmsi_pkg::tmsi_byte_t remoteTempHigh,
   input  wire tmsi_pkg::tmsi_byte_t remoteTempLow,
   input  wire tmsi_pkg::tmsi_byte_t statusFlags,
   // configuration outputs and one-cycle strobes
   output logic [7:0]              configuration,
   output logic [7:0]              conversionRate,
   output logic [7:0]              localHighLimit,
   output logic [7:0]              localLowLimit,
   output logic [7:0]              remoteHighLimitUpper,
   output logic [7:0]              remoteLowLimitUpper,
   output logic [7:0]              remoteOffsetUpper,
   output logic [7:0]              remoteOffsetLower,
   output logic [7:0]              remoteHighLimitLower,
   output logic [7:0]              remoteLowLimitLower,
   output logic [7:0]              remoteCriticalLimit,
   output logic [7:0]              localCriticalLimit,
   output logic [7:0]              criticalHysteresis,
   output logic [7:0]              alarmFilterCount,
   output logic [2:0]              alarmsNeeded,
   output logic                    singleMeasure,
   output logic                    statusRead,
   // bus
   tmsi_bus_if.device              bus
);
   import tmsi_pkg::*;

   // ----------------------------------------
   // pin synchronisers and edge detection
   // ----------------------------------------
   logic [1:0] clkSync;
   logic [1:0] datSync;
   logic       clkQ;
   logic       datQ;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         clkSync <= 2'b11;
         datSync <= 2'b11;
         clkQ    <= 1'b1;
         datQ    <= 1'b1;
      end else begin
         clkSync <= {clkSync[0], bus.busClk};
         datSync <= {datSync[0], bus.busData};
         clkQ    <= clkSync[1];
         datQ    <= datSync[1];
      end
   end
   logic clkRise;
   logic clkFall;
   logic startSeen;
   logic stopSeen;
   assign clkRise   = clkSync[1] & ~clkQ;
   assign clkFall   = ~clkSync[1] & clkQ;
   assign startSeen = clkSync[1] & clkQ & datQ & ~datSync[1];
   assign stopSeen  = clkSync[1] & clkQ & ~datQ & datSync[1];

   // ----------------------------------------
   // strap and idle timeout
   // ----------------------------------------
   logic [6:0] ownAddress;
   logic [1:0] altSync;
   always_ff @(posedge clk_sys) begin
      if (srst) altSync <= 2'b00;
      else      altSync <= {altSync[0], altAddress};
   end
   always_ff @(posedge clk_sys) begin
      if (srst) ownAddress <= `TMSI_ADDR_PRIMARY;
      else      ownAddress <= altSync[1] ? `TMSI_ADDR_ALTERNATE : `TMSI_ADDR_PRIMARY;
   end
   logic [31:0] idleCount;
   logic        timedOut;
   tmsi_dev_state_t state;
   always_ff @(posedge clk_sys) begin
      if (srst || state == TMSI_IDLE || clkRise || clkFall || startSeen || stopSeen) idleCount <= '0;
      else if (!timedOut) idleCount <= idleCount + 32'd1;
   end
   // counter only runs inside a transaction, so a quiet idle bus never fires
   assign timedOut = alarmFilterCount[`TMSI_TIMEOUT_BIT] && (idleCount >= TIMEOUT_CYCLES - 1);

   // ----------------------------------------
   // byte engine
   // ----------------------------------------
   logic [3:0] bitCount;
   logic [7:0] shiftReg;
   logic       isRead;
   logic [1:0] byteIndex;
   logic [7:0] pointer;
   logic [7:0] readData;
   logic       writeStrobe;
   logic       ptrStrobe;
   always_ff @(posedge clk_sys) begin
      writeStrobe <= 1'b0;
      ptrStrobe   <= 1'b0;
      if (srst || stopSeen || timedOut) begin
         state     <= TMSI_IDLE;
         bitCount  <= '0;
         shiftReg  <= '0;
         isRead    <= 1'b0;
         byteIndex <= '0;
      end else if (startSeen) begin
         state     <= TMSI_ADDR;
         bitCount  <= '0;
         byteIndex <= '0;
      end else begin
         case (state)
            TMSI_IDLE: ;
            TMSI_ADDR, TMSI_WBYTE: begin
               if (clkRise) begin
                  shiftReg <= {shiftReg[6:0], datQ};
                  bitCount <= bitCount + 4'd1;
               end else if (clkFall && bitCount == 4'd8) begin
                  bitCount <= '0;
                  if (state == TMSI_ADDR) begin
                     if (shiftReg[7:1] == ownAddress) begin
                        state  <= TMSI_AACK;
                        isRead <= shiftReg[0];
                     end else state <= TMSI_SKIP;
                  end else begin
                     state <= TMSI_WACK;
                     if (byteIndex == 2'd0) ptrStrobe <= 1'b1;
                     else if (byteIndex == 2'd1) writeStrobe <= 1'b1;
                     if (byteIndex != 2'd3) byteIndex <= byteIndex + 2'd1;
                  end
               end
            end
            TMSI_AACK, TMSI_WACK: begin
               if (clkFall) state <= (state == TMSI_AACK && isRead) ? TMSI_RBYTE : TMSI_WBYTE;
               if (clkFall && state == TMSI_AACK && isRead) shiftReg <= readData;
            end
            TMSI_RBYTE: begin
               if (clkFall) begin
                  bitCount <= bitCount + 4'd1;
                  shiftReg <= {shiftReg[6:0], 1'b0};
                  if (bitCount == 4'd7) state <= TMSI_RACK;
               end
            end
            TMSI_RACK: begin
               if (clkRise) state <= TMSI_SKIP;
            end
            TMSI_SKIP: ;
            default: state <= TMSI_IDLE;
         endcase
      end
   end
   // a third write byte is not acknowledged
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bus.devDataOut  <= 1'b0;
         bus.devDataOe_n <= 1'b1;
      end else begin
         bus.devDataOut  <= 1'b0;
         bus.devDataOe_n <= ~((state == TMSI_AACK) || (state == TMSI_WACK && byteIndex != 2'd3) ||
                              (state == TMSI_RBYTE && !shiftReg[7]));
      end
   end

   // ----------------------------------------
   // register map
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) pointer <= '0;
      else if (ptrStrobe) pointer <= shiftReg;
   end
   always_comb begin
      case (pointer)
         `TMSI_REG_LOCAL_TEMP: readData = localTemp;
         `TMSI_REG_REM_HI:     readData = remoteTempHigh;
         `TMSI_REG_STATUS:     readData = statusFlags;
         `TMSI_RD_CONFIG:      readData = configuration;
         `TMSI_RD_CONFIG + 8'h01: readData = conversionRate;
         `TMSI_RD_CONFIG + 8'h02: readData = localHighLimit;
         `TMSI_RD_CONFIG + 8'h03: readData = localLowLimit;
         `TMSI_RD_CONFIG + 8'h04: readData = remoteHighLimitUpper;
         `TMSI_RD_LAST_SPLIT:  readData = remoteLowLimitUpper;
         `TMSI_REG_REM_LO:     readData = remoteTempLow;
         `TMSI_REG_OFS_HI:     readData = remoteOffsetUpper;
         `TMSI_REG_OFS_LO:     readData = remoteOffsetLower;
         `TMSI_REG_RHL_LO:     readData = remoteHighLimitLower;
         `TMSI_REG_RLL_LO:     readData = remoteLowLimitLower;
         `TMSI_REG_REM_CRIT:   readData = remoteCriticalLimit;
         `TMSI_REG_LOC_CRIT:   readData = localCriticalLimit;
         `TMSI_REG_HYST:       readData = criticalHysteresis;
         `TMSI_REG_FILTER:     readData = alarmFilterCount;
         `TMSI_REG_MAKER:      readData = MAKER_CODE;
         `TMSI_REG_REVISION:   readData = REVISION_CODE;
         default:              readData = `TMSI_ZERO_BYTE;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      statusRead <= ~srst && clkFall && state == TMSI_AACK && isRead && pointer == `TMSI_REG_STATUS;
   end
   always_ff @(posedge clk_sys) begin
      singleMeasure <= ~srst && writeStrobe && pointer == `TMSI_WR_ONESHOT;
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         configuration        <= `TMSI_ZERO_BYTE;
         conversionRate       <= `TMSI_RST_CONVRATE;
         localHighLimit       <= `TMSI_RST_LIMIT_HI;
         localLowLimit        <= `TMSI_ZERO_BYTE;
         remoteHighLimitUpper <= `TMSI_RST_LIMIT_HI;
         remoteLowLimitUpper  <= `TMSI_ZERO_BYTE;
         remoteOffsetUpper    <= `TMSI_ZERO_BYTE;
         remoteOffsetLower    <= `TMSI_ZERO_BYTE;
         remoteHighLimitLower <= `TMSI_ZERO_BYTE;
         remoteLowLimitLower  <= `TMSI_ZERO_BYTE;
         remoteCriticalLimit  <= `TMSI_RST_LIMIT_HI;
         localCriticalLimit   <= `TMSI_RST_LIMIT_HI;
         criticalHysteresis   <= `TMSI_RST_HYST;
         alarmFilterCount     <= `TMSI_RST_FILTER;
      end else if (writeStrobe) begin
         case (pointer)
            `TMSI_WR_CONFIG:          configuration        <= shiftReg;
            `TMSI_WR_CONFIG + 8'h01:  conversionRate       <= shiftReg;
            `TMSI_WR_CONFIG + 8'h02:  localHighLimit       <= shiftReg;
            `TMSI_WR_CONFIG + 8'h03:  localLowLimit        <= shiftReg;
            `TMSI_WR_CONFIG + 8'h04:  remoteHighLimitUpper <= shiftReg;
            `TMSI_WR_LAST_SPLIT:      remoteLowLimitUpper  <= shiftReg;
            `TMSI_REG_OFS_HI:         remoteOffsetUpper    <= shiftReg;
            `TMSI_REG_OFS_LO:         remoteOffsetLower    <= shiftReg;
            `TMSI_REG_RHL_LO:         remoteHighLimitLower <= shiftReg;
            `TMSI_REG_RLL_LO:         remoteLowLimitLower  <= shiftReg;
            `TMSI_REG_REM_CRIT:       remoteCriticalLimit  <= shiftReg;
            `TMSI_REG_LOC_CRIT:       localCriticalLimit   <= shiftReg;
            `TMSI_REG_HYST:           criticalHysteresis   <= shiftReg;
            `TMSI_REG_FILTER:         alarmFilterCount     <= shiftReg;
            default: ;
         endcase
      end
   end
   // unlisted code 010 of the filter field maps to a count of 2, codes 100 to 110 to a count of 1
   always_ff @(posedge clk_sys) begin
      case (alarmFilterCount[3:1])
         3'b000:  alarmsNeeded <= 3'd1;
         3'b001:  alarmsNeeded <= 3'd2;
         3'b011:  alarmsNeeded <= 3'd3;
         3'b111:  alarmsNeeded <= 3'd4;
         3'b010:  alarmsNeeded <= 3'd2;
         default: alarmsNeeded <= 3'd1;
      endcase
   end
endmodule // tmsi_device
`default_nettype wire

// ==== core/tmsi_host.sv ====
// Purpose: serial master end issuing one register access per command
// Assumes: clock divider makes the bus clock from clk_sys
// Notes:   a write of one byte only sets the pointer
`default_nettype none
`include "tmsi_defines.svh"
module tmsi_host (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              srst,
   // command port
   input  wire logic              cmdValid,
   output logic                   cmdReady,
   input  wire logic              cmdRead,
   input  wire logic              cmdTwoBytes,
   input  wire logic [6:0]        cmdAddress,
   input  wire logic [7:0]        cmdPointer,
   input  wire logic [7:0]        cmdData,
   // answer port
   output logic                   rspValid,
   output logic [7:0]             rspData,
   output logic                   rspNack,
   // bus
   tmsi_bus_if.host               bus
);
   import tmsi_pkg::*;

   // ----------------------------------------
   // bit timing
   // ----------------------------------------
   logic [7:0] divCount;
   logic       tick;
   tmsi_host_state_t state;
   always_ff @(posedge clk_sys) begin
      if (srst || state == TMSH_IDLE) divCount <= '0;
      else if (tick) divCount <= '0;
      else divCount <= divCount + 8'd1;
   end
   assign tick = (divCount == 8'(`TMSI_HOST_HALF - 1));
   logic [1:0] datSync;
   always_ff @(posedge clk_sys) begin
      if (srst) datSync <= 2'b11;
      else      datSync <= {datSync[0], bus.busData};
   end

   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   logic [26:0] frame;
   logic [1:0]  bytesLeft;
   logic [4:0]  bitIndex;
   logic [7:0]  rxShift;
   logic        isReadFrame;
   logic        drvLow;
   logic        sclLow;
   assign cmdReady = (state == TMSH_IDLE);
   always_ff @(posedge clk_sys) begin
      rspValid <= 1'b0;
      if (srst) begin
         state <= TMSH_IDLE; frame <= '0; bytesLeft <= '0; bitIndex <= '0; rxShift <= '0;
         isReadFrame <= 1'b0; drvLow <= 1'b0; sclLow <= 1'b0; rspData <= '0; rspNack <= 1'b0;
      end else begin
         case (state)
            TMSH_IDLE: if (cmdValid) begin
               frame       <= {cmdAddress, cmdRead, 1'b1, cmdPointer, 1'b1, cmdData, 1'b1};
               isReadFrame <= cmdRead;
               bytesLeft   <= cmdRead ? 2'd1 : (cmdTwoBytes ? 2'd2 : 2'd1);
               bitIndex    <= '0; rspNack <= 1'b0;
               drvLow      <= 1'b1; state <= TMSH_START;
            end
            TMSH_START: if (tick) begin sclLow <= 1'b1; state <= TMSH_BITLO; end
            TMSH_BITLO: begin
               // data moves two cycles into the low phase (one for the first bit), never beside a clock edge
               drvLow <= (isReadFrame && bitIndex > 5'd8) ? 1'b0 : ~frame[26];
               if (tick) begin sclLow <= 1'b0; state <= TMSH_BITHI; end
            end
            TMSH_BITHI: if (tick) begin
               if (isReadFrame && bitIndex > 5'd8 && bitIndex < 5'd17) rxShift <= {rxShift[6:0], datSync[1]};
               if (datSync[1] && (bitIndex == 5'd8 || (!isReadFrame && (bitIndex == 5'd17 || bitIndex == 5'd26))))
                  rspNack <= 1'b1;
               frame <= {frame[25:0], 1'b1}; sclLow <= 1'b1; state <= TMSH_NEXT;
            end
            TMSH_NEXT: begin
               if ((bitIndex == 5'd17 && (bytesLeft == 2'd1 || isReadFrame)) || (bitIndex == 5'd26)) begin
                  state <= TMSH_STOPA;
                  if (isReadFrame) rspData <= rxShift;
               end else begin
                  bitIndex <= bitIndex + 5'd1;
                  if (bitIndex == 5'd17) bytesLeft <= bytesLeft - 2'd1;
                  state <= TMSH_BITLO;
               end
            end
            TMSH_STOPA: if (tick) begin drvLow <= 1'b1; state <= TMSH_STOPB; end
            TMSH_STOPB: if (tick) begin sclLow <= 1'b0; state <= TMSH_STOPC; end
            TMSH_STOPC: if (tick) begin drvLow <= 1'b0; state <= TMSH_DONE; end
            TMSH_DONE:  if (tick) begin rspValid <= 1'b1; state <= TMSH_IDLE; end
            default: state <= TMSH_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bus.hostClkOut <= 1'b0; bus.hostClkOe_n <= 1'b1;
         bus.hostDataOut <= 1'b0; bus.hostDataOe_n <= 1'b1;
      end else begin
         bus.hostClkOut <= 1'b0; bus.hostClkOe_n <= ~sclLow;
         bus.hostDataOut <= 1'b0; bus.hostDataOe_n <= ~drvLow;
      end
   end
endmodule // tmsi_host
`default_nettype wire

// ==== testbench/tmsi_bus_sva.sv ====
// Purpose: wire-level checks on the two-wire bus
// Assumes: one host end and one monitor end on the bus
// Notes:   counts clock pulses per frame in helper logic
`default_nettype none
module tmsi_bus_sva (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // bus
   input wire logic busClk,
   input wire logic busData,
   input wire logic devDataOut,
   input wire logic devDataOe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic       prevClk;
   logic       prevData;
   logic [7:0] pulses;
   always_ff @(posedge clk_sys) begin
      prevClk <= busClk;
      prevData <= busData;
   end
   // restart the pulse count at every start
   always_ff @(posedge clk_sys) begin
      if (srst || (prevClk && busClk && prevData && !busData)) begin
         pulses <= 8'h00;
      end else if (!prevClk && busClk) begin
         pulses <= pulses + 8'h01;
      end
   end
   chk_reset_release: assert property ($fell(srst) |-> devDataOe_n)
      else $error("monitor drives the bus right after reset");
   chk_open_drain: assert property (!devDataOe_n |-> !devDataOut)
      else $error("monitor drives data high");
   chk_dev_change_low: assert property ($changed(devDataOe_n) |-> !busClk)
      else $error("monitor changed data while clock high");
   chk_clk_high_width: assert property ($rose(busClk) |-> busClk [*6])
      else $error("clock high phase too short");
   chk_clk_low_width: assert property ($fell(busClk) |-> !busClk [*6])
      else $error("clock low phase too short");
   chk_ack_held: assert property ($fell(devDataOe_n) |-> ##[1:20] ($rose(busClk) && !devDataOe_n))
      else $error("monitor let go before the clock pulse");
   chk_quiet_stop: assert property (prevClk && busClk && !prevData && busData |-> devDataOe_n [*8])
      else $error("monitor drives after a stop");
   chk_frame_pulses: assert property (prevClk && busClk && !prevData && busData |-> pulses % 8'h09 == 8'h01)
      else $error("stop not on the pulse after a whole byte");
   cover property ($fell(devDataOe_n));
   cover property (prevClk && busClk && !prevData && busData);
   cover property (pulses == 8'h1c);
endmodule // tmsi_bus_sva
`default_nettype wire

// ==== testbench/tmsi_tb_top.sv ====
// Purpose: host and monitor ends joined, register traffic checked
// Assumes: host end issues whole frames per command
// Notes:   timeout not exercised, the host never stalls a frame
`default_nettype none
module tmsi_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tmsi_pkg::*;
   logic       clk_sys, srst, altAddress, cmdValid, cmdReady, cmdRead, cmdTwoBytes;
   logic       rspValid, rspNack, singleMeasure, statusRead;
   logic [6:0] cmdAddress;
   logic [7:0] cmdPointer, cmdData, rspData;
   logic [2:0] alarmsNeeded;
   tmsi_byte_t localTemp, remoteTempHigh, remoteTempLow, statusFlags;
   int         mismatches, comparisons, shots, reads;
   localparam logic [7:0] RA [22] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h10, 8'h11,
      8'h12, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'h22, 8'hfe, 8'hff, 8'h09, 8'h30};
   // maker and revision values are arbitrary
   localparam logic [7:0] RV [22] = '{8'h3c, 8'h5e, 8'h81, 8'h00, 8'h08, 8'h55, 8'h00, 8'h55, 8'h00, 8'h20, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h0a, 8'h01, 8'h3a, 8'h07, 8'h00, 8'h00};
   localparam logic [7:0] FC [5] = '{8'h00, 8'h02, 8'h06, 8'h0e, 8'h71};
   tmsi_bus_if bus ();
   tmsi_device #(.TIMEOUT_CYCLES(2000), .MAKER_CODE(8'h3a), .REVISION_CODE(8'h07)) tmsi_device_inst (
      .clk_sys(clk_sys), .srst(srst), .altAddress(altAddress), .localTemp(localTemp),
      .remoteTempHigh(remoteTempHigh), .remoteTempLow(remoteTempLow), .statusFlags(statusFlags),
      .configuration(), .conversionRate(), .localHighLimit(), .localLowLimit(), .remoteHighLimitUpper(),
      .remoteLowLimitUpper(), .remoteOffsetUpper(), .remoteOffsetLower(), .remoteHighLimitLower(),
      .remoteLowLimitLower(), .remoteCriticalLimit(), .localCriticalLimit(), .criticalHysteresis(),
      .alarmFilterCount(), .alarmsNeeded(alarmsNeeded), .singleMeasure(singleMeasure), .statusRead(statusRead),
      .bus(bus.device));
   tmsi_host tmsi_host_inst (.clk_sys(clk_sys), .srst(srst), .cmdValid(cmdValid), .cmdReady(cmdReady),
      .cmdRead(cmdRead), .cmdTwoBytes(cmdTwoBytes), .cmdAddress(cmdAddress), .cmdPointer(cmdPointer),
      .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .rspNack(rspNack), .bus(bus.host));
   tmsi_bus_sva tmsi_bus_sva_inst (.clk_sys(clk_sys), .srst(srst), .busClk(bus.busClk), .busData(bus.busData),
      .devDataOut(bus.devDataOut), .devDataOe_n(bus.devDataOe_n));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // pulses are counted mid-cycle, where they are settled
   always @(negedge clk_sys) begin
      if (singleMeasure === 1'b1) shots++;
      if (statusRead === 1'b1) reads++;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one whole frame; a frame that never answers ends the run
   task automatic xfer(input logic rd, input logic two, input logic [6:0] adr, input logic [7:0] ptr,
                       input logic [7:0] dat, input logic expNack);
      int n;
      n = 0;
      while (cmdReady !== 1'b1 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      {cmdValid, cmdRead, cmdTwoBytes, cmdAddress, cmdPointer, cmdData} = {1'b1, rd, two, adr, ptr, dat};
      @(negedge clk_sys);
      cmdValid = 1'b0;
      while (rspValid !== 1'b1 && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 3000) begin
         mismatches++;
         wrap_up();
      end else begin
         check("nack", {7'h00, rspNack}, {7'h00, expNack});
      end
   endtask
   task automatic peek(input logic [7:0] ptr, input logic [7:0] exp);
      xfer(1'b0, 1'b0, 7'h4c, ptr, 8'h00, 1'b0);
      xfer(1'b1, 1'b0, 7'h4c, 8'h00, 8'h00, 1'b0);
      check("read data", rspData, exp);
   endtask
   initial begin
      {srst, altAddress, cmdValid, cmdRead, cmdTwoBytes, cmdAddress, cmdPointer, cmdData} = {3'b100, 2'b00, 7'h00,
         16'h0000};
      {localTemp, remoteTempHigh, remoteTempLow, statusFlags} = {8'h3c, 8'h5e, 8'h20, 8'h81};
      repeat (6) @(negedge clk_sys);
      srst = 1'b0;
      repeat (4) @(negedge clk_sys);
      for (int i = 0; i < 22; i++) peek(RA[i], RV[i]);
      check("status reads", reads[7:0], 8'h01);
      $display("test reset values done");
      for (int i = 3; i < 17; i++) begin
         if (i == 9) continue;
         xfer(1'b0, 1'b1, 7'h4c, (RA[i] < 8'h09) ? RA[i] + 8'h06 : RA[i], 8'hc0 + 8'(i), 1'b0);
         peek(RA[i], 8'hc0 + 8'(i));
      end
      xfer(1'b0, 1'b1, 7'h4c, 8'h03, 8'h11, 1'b0);
      peek(8'h03, 8'hc3);
      xfer(1'b1, 1'b0, 7'h4c, 8'h00, 8'h00, 1'b0);
      check("reread", rspData, 8'hc3);
      xfer(1'b0, 1'b1, 7'h4c, 8'h30, 8'h5a, 1'b0);
      peek(8'h30, 8'h00);
      $display("test register writes done");
      xfer(1'b0, 1'b1, 7'h4c, 8'h0f, 8'h77, 1'b0);
      check("shots", shots[7:0], 8'h01);
      peek(8'h0f, 8'h00);
      check("shots", shots[7:0], 8'h01);
      $display("test one shot done");
      for (int i = 0; i < 5; i++) begin
         xfer(1'b0, 1'b1, 7'h4c, 8'h22, FC[i], 1'b0);
         check("alarms", {5'h00, alarmsNeeded}, (i == 4) ? 8'h01 : 8'(i + 1));
      end
      xfer(1'b0, 1'b1, 7'h4c, 8'h22, 8'h8e, 1'b0);
      peek(8'h22, 8'h8e);
      check("alarms", {5'h00, alarmsNeeded}, 8'h04);
      $display("test filter count done");
      xfer(1'b1, 1'b0, 7'h4d, 8'h00, 8'h00, 1'b1);
      altAddress = 1'b1;
      xfer(1'b1, 1'b0, 7'h4d, 8'h00, 8'h00, 1'b0);
      xfer(1'b0, 1'b0, 7'h4c, 8'h00, 8'h00, 1'b1);
      $display("test addressing done");
      wrap_up();
   end
endmodule // tmsi_tb_top
`default_nettype wire
